// [hdl/spf_pkg.sv]
// Package for the self-programming fuse, lock and signature readout block
package spf_pkg;
  // Control register bit positions
  localparam int unsigned CTL_ENABLE_BIT   = 0;
  localparam int unsigned CTL_ERASE_BIT    = 1;
  localparam int unsigned CTL_PAGE_WR_BIT  = 2;
  localparam int unsigned CTL_LOCKSEL_BIT  = 3;
  localparam int unsigned CTL_REENABLE_BIT = 4;
  localparam int unsigned CTL_SIGSEL_BIT   = 5;
  localparam int unsigned CTL_BUSY_BIT     = 6;
  localparam logic [7:0]  CTL_RESET        = 8'h00;

  // Z addresses for fuse and lock readout
  localparam logic [15:0] Z_FUSE_LOW       = 16'h0000;
  localparam logic [15:0] Z_LOCK           = 16'h0001;
  localparam logic [15:0] Z_FUSE_EXT       = 16'h0002;
  localparam logic [15:0] Z_FUSE_HIGH      = 16'h0003;

  // Z addresses for signature row
  localparam logic [15:0] Z_SIG_BYTE1      = 16'h0000;
  localparam logic [15:0] Z_SIG_CAL        = 16'h0001;
  localparam logic [15:0] Z_SIG_BYTE2      = 16'h0002;
  localparam logic [15:0] Z_SIG_BYTE3      = 16'h0004;

  // Windows in CPU cycles after the control write
  localparam logic [2:0]  LOAD_WINDOW      = 3'h3;
  localparam logic [2:0]  STORE_WINDOW     = 3'h4;

  // Flash write timing
  localparam real         CLK_MHZ          = 40.0;
  localparam real         WRITE_MIN_US     = 3700.0;
  localparam real         WRITE_MAX_US     = 4500.0;
  localparam int unsigned WRITE_MIN_CYC    = int'($ceil(WRITE_MIN_US * CLK_MHZ));
  localparam int unsigned WRITE_MAX_CYC    = int'($floor(WRITE_MAX_US * CLK_MHZ));
  localparam int unsigned WRITE_CNT_W      = 18;

  // Arbitrary neutral signature values
  localparam logic [7:0]  SIG_BYTE1_DEF    = 8'h5a;
  localparam logic [7:0]  SIG_BYTE2_DEF    = 8'h01;
  localparam logic [7:0]  SIG_BYTE3_DEF    = 8'h02;
  localparam logic [7:0]  RESERVED_READ    = 8'hff;

  typedef enum logic [1:0] {
    SPF_IDLE,
    SPF_WRITE,
    SPF_READ_WIN
  } spf_state_t;
endpackage

// [hdl/spf_readout_mux.sv]
// Registered selector for fuse, lock and signature readout bytes
`timescale 1ns/100ps
`default_nettype none
module spf_readout_mux (
  input  wire logic        clk_i,        // CPU clock
  input  wire logic        resetn_i,     // Async reset, active low
  input  wire logic [15:0] z_addr_i,     // Z pointer
  input  wire logic        sig_sel_i,    // Signature row selected
  input  wire logic [7:0]  fuse_low_i,   // Low fuse byte
  input  wire logic [7:0]  fuse_high_i,  // High fuse byte
  input  wire logic [7:0]  fuse_ext_i,   // Extended fuse byte
  input  wire logic [7:0]  lock_i,       // Lock bits
  input  wire logic [7:0]  osc_cal_i,    // RC calibration byte
  input  wire logic [7:0]  sig1_i,       // Signature byte 1
  input  wire logic [7:0]  sig2_i,       // Signature byte 2
  input  wire logic [7:0]  sig3_i,       // Signature byte 3
  output logic      [7:0]  data_o        // Selected byte, registered
);
  import spf_pkg::*;

  logic [7:0] data_reg;
  logic [7:0] data_next;

  // Fuse and lock bits arrive as stored: programmed cell is zero
  always_comb begin
    data_next = RESERVED_READ;
    if (sig_sel_i) begin
      unique case (z_addr_i)
        Z_SIG_BYTE1: data_next = sig1_i;
        Z_SIG_CAL:   data_next = osc_cal_i;
        Z_SIG_BYTE2: data_next = sig2_i;
        Z_SIG_BYTE3: data_next = sig3_i;
        default:     data_next = RESERVED_READ;
      endcase
    end else begin
      unique case (z_addr_i)
        Z_FUSE_LOW:  data_next = fuse_low_i;
        Z_LOCK:      data_next = lock_i;
        Z_FUSE_EXT:  data_next = fuse_ext_i;
        Z_FUSE_HIGH: data_next = fuse_high_i;
        default:     data_next = RESERVED_READ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_reg <= 8'h00;
    end else begin
      data_reg <= data_next;
    end
  end

  assign data_o = data_reg;
endmodule
`default_nettype wire

// [hdl/spf_write_timer.sv]
// Flash write duration timer, kept running through system reset
`timescale 1ns/100ps
`default_nettype none
module spf_write_timer #(
  parameter int unsigned WRITE_CYCLES = spf_pkg::WRITE_MIN_CYC // Write length
) (
  input  wire logic clk_i,       // Calibrated RC derived clock
  input  wire logic por_n_i,     // Power-on reset only, active low
  input  wire logic start_i,     // Start pulse
  output logic      busy_o       // Write in progress, registered
);
  import spf_pkg::*;

  logic [WRITE_CNT_W-1:0] cnt_reg;
  logic [WRITE_CNT_W-1:0] cnt_next;
  logic                   busy_reg;
  logic                   busy_next;

  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    if (start_i && !busy_reg) begin
      cnt_next  = WRITE_CNT_W'(WRITE_CYCLES - 1);
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == '0) begin
        busy_next = 1'b0;
      end else begin
        cnt_next = cnt_reg - 1'b1;
      end
    end
  end

  // Only power-on clears it, so a system reset cannot cut a write short
  always_ff @(posedge clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign busy_o = busy_reg;
endmodule
`default_nettype wire

// [hdl/spf_self_prog.sv]
// Self-programming control: timed windows, fuse/lock/signature readout, write blocking
`timescale 1ns/100ps
`default_nettype none
module spf_self_prog #(
  parameter int unsigned WRITE_CYCLES = spf_pkg::WRITE_MIN_CYC // Flash write length
) (
  input  wire logic        clk_i,           // CPU clock, 40 MHz
  input  wire logic        resetn_i,        // System reset, async, active low
  input  wire logic        por_n_i,         // Power-on reset, async, active low
  input  wire logic        ctl_wr_i,        // Control register write strobe
  input  wire logic [7:0]  ctl_wdata_i,     // Control register write data
  input  wire logic        eeprom_write_busy_i, // EEPROM write in progress
  input  wire logic        load_i,          // Program-memory load executes
  input  wire logic        store_i,         // Program-memory store executes
  input  wire logic [15:0] z_addr_i,        // Z pointer
  input  wire logic [7:0]  flash_data_i,    // Ordinary flash byte at Z
  input  wire logic [7:0]  fuse_low_byte_i, // Low fuse byte
  input  wire logic [7:0]  fuse_high_byte_i, // High fuse byte
  input  wire logic [7:0]  fuse_extended_byte_i, // Extended fuse byte
  input  wire logic [7:0]  lock_bits_i,     // Lock bits
  input  wire logic [7:0]  osc_cal_i,       // RC calibration byte
  input  wire logic [7:0]  sig1_i,          // Signature byte 1
  input  wire logic [7:0]  sig2_i,          // Signature byte 2
  input  wire logic [7:0]  sig3_i,          // Signature byte 3
  output logic      [7:0]  self_prog_control_reg_o, // Control register readback
  output logic      [7:0]  load_data_o,     // Load result, valid with load_valid_o
  output logic             load_valid_o,    // Load result pulse
  output logic             flash_write_start_o, // Start of a flash write pulse
  output logic             lock_write_o     // Lock write request pulse
);
  import spf_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // State

  spf_state_t state_reg;
  spf_state_t state_next;
  logic       lock_fuse_access_select_reg;
  logic       lock_fuse_access_select_next;
  logic       signature_read_select_reg;
  logic       signature_read_select_next;
  logic       self_prog_enable_reg;
  logic       self_prog_enable_next;
  logic       page_erase_select_reg;
  logic       page_erase_select_next;
  logic       page_write_select_reg;
  logic       page_write_select_next;
  logic       reenable_reg;
  logic       reenable_next;
  logic       section_busy_reg;
  logic       section_busy_next;
  logic [2:0] win_cnt_reg;
  logic [2:0] win_cnt_next;
  logic [7:0] load_data_reg;
  logic [7:0] load_data_next;
  logic       load_valid_reg;
  logic       load_valid_next;
  logic       wr_start_reg;
  logic       wr_start_next;
  logic       lock_wr_reg;
  logic       lock_wr_next;
  logic [7:0] ctl_out_reg;
  logic [7:0] ctl_out_next;

  logic       write_busy;
  logic [7:0] special_data;
  logic       readout_hit;
  logic       readout_hit_d;
  logic       store_open;
  logic       load_open;

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  spf_readout_mux u_mux (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .z_addr_i    (z_addr_i),
    .sig_sel_i   (signature_read_select_reg),
    .fuse_low_i  (fuse_low_byte_i),
    .fuse_high_i (fuse_high_byte_i),
    .fuse_ext_i  (fuse_extended_byte_i),
    .lock_i      (lock_bits_i),
    .osc_cal_i   (osc_cal_i),
    .sig1_i      (sig1_i),
    .sig2_i      (sig2_i),
    .sig3_i      (sig3_i),
    .data_o      (special_data)
  );

  // Flash write length kept on the power-on reset only
  spf_write_timer #(
    .WRITE_CYCLES (WRITE_CYCLES)
  ) u_timer (
    .clk_i   (clk_i),
    .por_n_i (por_n_i),
    .start_i (wr_start_reg),
    .busy_o  (write_busy)
  );

  // Windows count from the cycle after the control write
  assign load_open  = (state_reg == SPF_READ_WIN) && (win_cnt_reg < LOAD_WINDOW);
  assign store_open = (state_reg == SPF_READ_WIN) && (win_cnt_reg < STORE_WINDOW);
  assign readout_hit = load_open && load_i &&
                       (lock_fuse_access_select_reg || signature_read_select_reg);

  //////////////////////////////////////////////////////////////////////////
  // Control and windows

  always_comb begin
    state_next                   = state_reg;
    lock_fuse_access_select_next = lock_fuse_access_select_reg;
    signature_read_select_next   = signature_read_select_reg;
    self_prog_enable_next        = self_prog_enable_reg;
    page_erase_select_next       = page_erase_select_reg;
    page_write_select_next       = page_write_select_reg;
    reenable_next                = reenable_reg;
    section_busy_next            = section_busy_reg;
    win_cnt_next                 = win_cnt_reg;
    wr_start_next                = 1'b0;
    lock_wr_next                 = 1'b0;
    unique case (state_reg)
      SPF_IDLE: begin
        // Control writes while EEPROM busy are dropped outright; a write that
        // survived a system reset also keeps new commands out until it ends
        if (ctl_wr_i && !eeprom_write_busy_i && !write_busy &&
            ctl_wdata_i[CTL_ENABLE_BIT]) begin
          self_prog_enable_next        = 1'b1;
          lock_fuse_access_select_next = ctl_wdata_i[CTL_LOCKSEL_BIT];
          signature_read_select_next   = ctl_wdata_i[CTL_SIGSEL_BIT];
          page_erase_select_next       = ctl_wdata_i[CTL_ERASE_BIT];
          page_write_select_next       = ctl_wdata_i[CTL_PAGE_WR_BIT];
          reenable_next                = ctl_wdata_i[CTL_REENABLE_BIT];
          win_cnt_next                 = 3'h0;
          state_next                   = SPF_READ_WIN;
        end
      end
      SPF_READ_WIN: begin
        win_cnt_next = win_cnt_reg + 3'h1;
        if (readout_hit) begin
          state_next = SPF_IDLE;
        end else if (store_open && store_i && !signature_read_select_reg) begin
          if (reenable_reg) begin
            section_busy_next = 1'b0;
            state_next        = SPF_IDLE;
          end else begin
            wr_start_next = page_erase_select_reg || page_write_select_reg ||
                            lock_fuse_access_select_reg;
            lock_wr_next  = lock_fuse_access_select_reg;
            if (page_erase_select_reg || page_write_select_reg) begin
              section_busy_next = 1'b1;
            end
            state_next = SPF_WRITE;
          end
        end else if (signature_read_select_reg || lock_fuse_access_select_reg) begin
          // Readout windows close after the load window, or the store window
          if (signature_read_select_reg && win_cnt_reg >= LOAD_WINDOW - 3'h1) begin
            state_next = SPF_IDLE;
          end else if (win_cnt_reg >= STORE_WINDOW - 3'h1) begin
            state_next = SPF_IDLE;
          end
        end else if (win_cnt_reg >= STORE_WINDOW - 3'h1) begin
          state_next = SPF_IDLE;
        end
        if (state_next == SPF_IDLE) begin
          self_prog_enable_next        = 1'b0;
          lock_fuse_access_select_next = 1'b0;
          signature_read_select_next   = 1'b0;
          page_erase_select_next       = 1'b0;
          page_write_select_next       = 1'b0;
          reenable_next                = 1'b0;
        end
      end
      SPF_WRITE: begin
        // Enable stays high until the timed write ends
        if (!wr_start_reg && !write_busy) begin
          state_next                   = SPF_IDLE;
          self_prog_enable_next        = 1'b0;
          lock_fuse_access_select_next = 1'b0;
          page_erase_select_next       = 1'b0;
          page_write_select_next       = 1'b0;
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Load path and readback

  always_comb begin
    load_valid_next = readout_hit_d || load_i;
    load_data_next  = flash_data_i;
    ctl_out_next    = CTL_RESET;
    // Enable reads set while a write runs on past a system reset
    ctl_out_next[CTL_ENABLE_BIT]   = self_prog_enable_next || write_busy;
    ctl_out_next[CTL_ERASE_BIT]    = page_erase_select_next;
    ctl_out_next[CTL_PAGE_WR_BIT]  = page_write_select_next;
    ctl_out_next[CTL_LOCKSEL_BIT]  = lock_fuse_access_select_next;
    ctl_out_next[CTL_REENABLE_BIT] = reenable_next;
    ctl_out_next[CTL_SIGSEL_BIT]   = signature_read_select_next;
    ctl_out_next[CTL_BUSY_BIT]     = section_busy_next;
  end

  // Special byte arrives one cycle after the load, from the mux register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      readout_hit_d <= 1'b0;
    end else begin
      readout_hit_d <= readout_hit;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg                   <= SPF_IDLE;
      lock_fuse_access_select_reg <= 1'b0;
      signature_read_select_reg   <= 1'b0;
      self_prog_enable_reg        <= 1'b0;
      page_erase_select_reg       <= 1'b0;
      page_write_select_reg       <= 1'b0;
      reenable_reg                <= 1'b0;
      section_busy_reg            <= 1'b0;
      win_cnt_reg                 <= 3'h0;
      wr_start_reg                <= 1'b0;
      lock_wr_reg                 <= 1'b0;
      load_valid_reg              <= 1'b0;
      load_data_reg               <= 8'h00;
      ctl_out_reg                 <= CTL_RESET;
    end else begin
      state_reg                   <= state_next;
      lock_fuse_access_select_reg <= lock_fuse_access_select_next;
      signature_read_select_reg   <= signature_read_select_next;
      self_prog_enable_reg        <= self_prog_enable_next;
      page_erase_select_reg       <= page_erase_select_next;
      page_write_select_reg       <= page_write_select_next;
      reenable_reg                <= reenable_next;
      section_busy_reg            <= section_busy_next;
      win_cnt_reg                 <= win_cnt_next;
      wr_start_reg                <= wr_start_next;
      lock_wr_reg                 <= lock_wr_next;
      load_valid_reg              <= load_valid_next && !readout_hit;
      if (readout_hit_d) begin
        load_data_reg <= special_data;
      end else if (load_i && !readout_hit) begin
        load_data_reg <= load_data_next;
      end
      ctl_out_reg                 <= ctl_out_next;
    end
  end

  assign self_prog_control_reg_o = ctl_out_reg;
  assign load_data_o             = load_data_reg;
  assign load_valid_o            = load_valid_reg;
  assign flash_write_start_o     = wr_start_reg;
  assign lock_write_o            = lock_wr_reg;
endmodule
`default_nettype wire

// [testbench/spf_self_prog_asserts.sv]
// Port-level assertion checker for the self-programming readout block
`timescale 1ns/100ps
`default_nettype none
module spf_self_prog_asserts #(
  parameter int unsigned WRITE_CYCLES = spf_pkg::WRITE_MIN_CYC // Flash write length
) (
  input  wire logic       clk_i,                   // CPU clock
  input  wire logic       resetn_i,                // Async reset, active low
  input  wire logic       ctl_wr_i,                // Control write strobe
  input  wire logic       eeprom_write_busy_i,     // EEPROM write busy
  input  wire logic       load_i,                  // Load pulse
  input  wire logic       store_i,                 // Store pulse
  input  wire logic [7:0] flash_data_i,            // Ordinary flash byte
  input  wire logic [7:0] self_prog_control_reg_o, // Control readback
  input  wire logic [7:0] load_data_o,             // Load result
  input  wire logic       load_valid_o,            // Load result pulse
  input  wire logic       flash_write_start_o,     // Write start pulse
  input  wire logic       lock_write_o             // Lock write pulse
);
  import spf_pkg::*;
  wire logic        en   = self_prog_control_reg_o[CTL_ENABLE_BIT];
  wire logic        lsel = self_prog_control_reg_o[CTL_LOCKSEL_BIT];
  wire logic        ssel = self_prog_control_reg_o[CTL_SIGSEL_BIT];
  wire logic        busy = self_prog_control_reg_o[CTL_BUSY_BIT];
  wire logic        spec = en && (lsel || ssel);
  logic      [31:0] wr_cnt_reg;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Cycles with enable held after a write start; zero when no write
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_cnt_reg <= 32'h0;
    end else if (flash_write_start_o) begin
      wr_cnt_reg <= 32'h1;
    end else if (wr_cnt_reg != 32'h0 && en) begin
      wr_cnt_reg <= wr_cnt_reg + 32'h1;
    end else begin
      wr_cnt_reg <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_ee_blocks_ctl: assert property (ctl_wr_i && eeprom_write_busy_i && !en |=> !en)
    else $error("control write accepted while eeprom busy");
  chk_start_cause: assert property (flash_write_start_o |-> $past(store_i) && $past(en))
    else $error("write start without store in window");
  chk_lock_pulse: assert property (lock_write_o |-> flash_write_start_o && $past(lsel))
    else $error("lock write pulse without lock store");
  chk_busy_set: assert property (flash_write_start_o && !lock_write_o |-> busy)
    else $error("section busy flag not set on page write");
  chk_plain_load: assert property (
    load_i && !en |=> load_valid_o && load_data_o == $past(flash_data_i))
    else $error("ordinary load result wrong");
  chk_spec_latency: assert property (load_i && spec |=> !load_valid_o ##1 load_valid_o)
    else $error("special load result not two cycles late");
  chk_read_close: assert property (load_i && spec |=> !en)
    else $error("enable not cleared after special read");
  chk_sig_close: assert property ($rose(ssel) |-> ##[1:4] !en)
    else $error("signature window did not close");
  chk_lock_close: assert property (
    $rose(lsel) && !store_i ##1 !store_i [*3] |-> ##[1:3] !en)
    else $error("lock window did not close");
  chk_write_min: assert property (!en && wr_cnt_reg != 32'h0 |-> wr_cnt_reg >= WRITE_CYCLES - 3)
    else $error("flash write ended early");
  chk_write_max: assert property (wr_cnt_reg <= WRITE_CYCLES + 4)
    else $error("flash write ran too long");
endmodule

bind spf_self_prog spf_self_prog_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.*);
`default_nettype wire

// [testbench/spf_self_prog_tb.sv]
// Self-checking bench for the self-programming readout block
`timescale 1ns/100ps
`default_nettype none
module spf_self_prog_tb;
  import spf_pkg::*;
  localparam int unsigned WCYC = 20;
  logic        clk_i        = 1'b0;
  logic        resetn_i     = 1'b0;
  logic        por_n_i      = 1'b0;
  int          wn           = 0;
  logic        ctl_wr_i     = 1'b0;
  logic        ee_busy      = 1'b0;
  logic        load_i       = 1'b0;
  logic        store_i      = 1'b0;
  logic [7:0]  ctl_wdata_i  = 8'h00;
  logic [15:0] z_addr_i     = 16'h0000;
  logic [7:0]  flash_data_i = 8'h00;
  logic [7:0]  raw [8]      = '{default: 8'h00};
  logic [7:0]  ops [3]      = '{8'h03, 8'h05, 8'h09};
  logic [7:0]  ctl_o;
  logic [7:0]  ld_data;
  logic        ld_valid;
  logic        wr_start;
  logic        lock_wr;
  int          lk_map [5]   = '{0, 3, 2, 1, -1};
  int          sg_map [5]   = '{5, 4, 6, -1, 7};
  int          exp_q [$];
  int          miscompares  = 0;
  int          compares     = 0;
  int          seed         = 32'h29f9;
  int          cyc          = 0;

  spf_self_prog #(.WRITE_CYCLES(WCYC)) u_dut (
    .clk_i                   (clk_i),
    .resetn_i                (resetn_i),
    .por_n_i                 (por_n_i),
    .ctl_wr_i                (ctl_wr_i),
    .ctl_wdata_i             (ctl_wdata_i),
    .eeprom_write_busy_i     (ee_busy),
    .load_i                  (load_i),
    .store_i                 (store_i),
    .z_addr_i                (z_addr_i),
    .flash_data_i            (flash_data_i),
    .fuse_low_byte_i         (raw[0]),
    .fuse_high_byte_i        (raw[1]),
    .fuse_extended_byte_i    (raw[2]),
    .lock_bits_i             (raw[3]),
    .osc_cal_i               (raw[4]),
    .sig1_i                  (raw[5]),
    .sig2_i                  (raw[6]),
    .sig3_i                  (raw[7]),
    .self_prog_control_reg_o (ctl_o),
    .load_data_o             (ld_data),
    .load_valid_o            (ld_valid),
    .flash_write_start_o     (wr_start),
    .lock_write_o            (lock_wr)
  );

  always #12.5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick();
    @(negedge clk_i);
  endtask

  // Unmapped addresses read all ones, as the design settles reserved places
  function automatic int model(input int mode, input int z);
    int idx;
    idx = (z > 4) ? -1 : (mode == 1) ? lk_map[z] : sg_map[z];
    if (mode == 0) return flash_data_i;
    return (idx < 0) ? 255 : raw[idx];
  endfunction

  // EEPROM busy is raised only in the blocking
  task automatic wr_ctl(input logic [7:0] v);
    ctl_wr_i = 1'b1;
    ctl_wdata_i = v;
    tick();
    ctl_wr_i = 1'b0;
  endtask

  task automatic do_load(input int mode, input int z);
    int i;
    z_addr_i = 16'(z);
    flash_data_i = 8'($random(seed));
    load_i = 1'b1;
    exp_q.push_back(model(mode, z));
    tick();
    load_i = 1'b0;
    for (i = 0; i < 4 && ld_valid !== 1'b1; i++) tick();
    tick();
    check("load_drained", 32'(exp_q.size()), 0);
  endtask

  task automatic special(input logic [7:0] v, input int z, input int gap, input logic ok);
    wr_ctl(v);
    check("enable_set", 32'(ctl_o[CTL_ENABLE_BIT]), 32'(ok));
    repeat (gap - 1) tick();
    do_load(ok ? (v[CTL_SIGSEL_BIT] ? 2 : 1) : 0, z);
    check("enable_clear", 32'(ctl_o[CTL_ENABLE_BIT]), 0);
    // Gap keeps the next window apart from the previous one
    repeat (2) tick();
  endtask

  task automatic prog(input logic [7:0] v);
    int n;
    n = 0;
    wr_ctl(v);
    store_i = 1'b1;
    tick();
    store_i = 1'b0;
    check("write_start", 32'(wr_start), 32'(!ee_busy));
    check("lock_write", 32'(lock_wr), 32'(!ee_busy && v[CTL_LOCKSEL_BIT]));
    while (ctl_o[CTL_ENABLE_BIT] === 1'b1 && n < WCYC + 10) begin
      tick();
      n++;
    end
    if (ee_busy === 1'b0) begin
      check("write_len", 32'(n >= WCYC - 3 && n <= WCYC + 3), 1);
      if (!v[CTL_LOCKSEL_BIT]) begin
        check("section_busy", 32'(ctl_o[CTL_BUSY_BIT]), 1);
        wr_ctl(8'h11);
        store_i = 1'b1;
        tick();
        store_i = 1'b0;
        for (n = 0; n < 8 && ctl_o !== 8'h00; n++) tick();
        check("section_reenabled", 32'(ctl_o), 0);
      end
    end
    tick();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk_i) begin
    if (ld_valid === 1'b1) begin
      check("load_data", 32'(ld_data), (exp_q.size() != 0) ? exp_q.pop_front() : 256);
    end
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    resetn_i = 1'b1;
    por_n_i = 1'b1;
    tick();
    foreach (raw[i]) raw[i] = 8'($random(seed));
    // All programmed and none programmed as boundary bytes
    raw[0] = 8'h00;
    raw[1] = 8'hff;
    for (int z = 0; z < 6; z++) special(8'h09, z, 1 + z % 3, 1'b1);
    $display("test fuse and lock readout done");
    for (int z = 0; z < 6; z++) special(8'h21, z, 3 - z % 3, 1'b1);
    $display("test signature readout done");
    for (int i = 0; i < 2; i++) begin
      wr_ctl(i ? 8'h21 : 8'h09);
      repeat (6) tick();
      check("window_timeout", 32'(ctl_o), 0);
      do_load(0, $unsigned($random(seed)) % 4);
    end
    $display("test window timeout done");
    foreach (ops[i]) prog(ops[i]);
    $display("test flash writes done");
    // System reset in mid-write: the write runs on and enable shows it
    wr_ctl(8'h05);
    store_i = 1'b1;
    tick();
    store_i = 1'b0;
    repeat (4) tick();
    resetn_i = 1'b0;
    tick();
    check("reset_clears", 32'(ctl_o), 0);
    resetn_i = 1'b1;
    tick();
    check("write_survives", 32'(ctl_o[CTL_ENABLE_BIT]), 1);
    wn = 6;
    while (ctl_o[CTL_ENABLE_BIT] === 1'b1 && wn < WCYC + 10) begin
      tick();
      wn++;
    end
    check("reset_write_len", 32'(wn >= WCYC - 3 && wn <= WCYC + 3), 1);
    tick();
    $display("test write across reset done");
    ee_busy = 1'b1;
    prog(8'h05);
    special(8'h09, 1, 1, 1'b0);
    special(8'h21, 0, 1, 1'b0);
    ee_busy = 1'b0;
    $display("test eeprom busy blocking done");
    finish_test();
  end
endmodule
`default_nettype wire
